// [rtl/uaft_pkg.sv]
package uaft_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the three address lines
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_ISR_FCR = 3'h2;
	localparam logic [2:0] OFS_LCR = 3'h3;
	localparam logic [2:0] OFS_EFR = 3'h4;
	localparam logic [2:0] OFS_FEATURE_CONTROL_REG = 3'h5;
	localparam logic [2:0] OFS_TRG = 3'h6;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_DMA = 3;
	localparam int FCR_TXT = 4;
	localparam int FCR_RXT = 6;
	localparam int EFR_ENH = 4;
	localparam int FEATURE_CONTROL_REG_TBL = 4;
	localparam int FEATURE_CONTROL_REG_TSEL = 7;
	localparam int ISR_FEN = 6;

	////////////////////////////////////////////////////////////////////////
	// Values
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_RX_READY_PIN_N = 4'h4;
	localparam logic [3:0] ISR_TX_READY_PIN_N = 4'h2;
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [7:0] TRG_RST = 8'h01;
	localparam logic [3:0] CHAR_LEN_MIN = 4'h5;

	////////////////////////////////////////////////////////////////////////
	// Trigger tables, entry index is the two-bit trigger field
	localparam logic [7:0] TX_LVL_A = 8'h01;
	localparam logic [3:0][7:0] RX_TBL_A = {8'h0e, 8'h08, 8'h04, 8'h01};
	localparam logic [3:0][7:0] TX_TBL_B = {8'h1e, 8'h18, 8'h08, 8'h10};
	localparam logic [3:0][7:0] RX_TBL_B = {8'h1c, 8'h18, 8'h10, 8'h08};
	localparam logic [3:0][7:0] TX_TBL_C = {8'h38, 8'h20, 8'h10, 8'h08};
	localparam logic [3:0][7:0] RX_TBL_C = {8'h3c, 8'h38, 8'h10, 8'h08};

endpackage

// [rtl/uaft_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface uaft_fifo_if #(parameter int W = 8, parameter int D = 32);
	logic clear;
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	logic [$clog2(D):0] count;

	modport store(input clear, wdata, wvalid, rready, output wready, rvalid, rdata, count);
	modport user(output clear, wdata, wvalid, rready, input wready, rvalid, rdata, count);
endinterface

`default_nettype wire

// [rtl/uaft_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

// Depth must be a power of two: pointers wrap by overflow
module uaft_fifo #(parameter int W = 8, parameter int D = 32) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Queue
	uaft_fifo_if.store q
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign q.wready = cnt_r != (AW+1)'(D);
	assign q.rvalid = cnt_r != '0;
	assign q.rdata = mem[rp_r];
	assign q.count = cnt_r;
	assign push = q.wvalid && q.wready;
	assign pop = q.rvalid && q.rready;

	always_ff @(posedge mclk) begin
		if (push)
			mem[wp_r] <= q.wdata;
	end

	// Clear drops pointers and level only; stored words are left in place
	always_ff @(posedge mclk) begin
		if (rst || q.clear) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	fifo_bound_a: assert property (cnt_r <= (AW+1)'(D))
		else $error("fifo level above depth");
	fifo_clear_a: assert property (q.clear |=> cnt_r == '0 && wp_r == rp_r)
		else $error("fifo clear left a level");
endmodule

`default_nettype wire

// [rtl/uaft_trig_sel.sv]
`timescale 1ns/1ps
`default_nettype none

module uaft_trig_sel
	import uaft_pkg::*;
(
	// Selection
	input wire logic [1:0] tbl,
	input wire logic [1:0] rx_fld,
	input wire logic [1:0] tx_fld,
	// Programmed levels
	input wire logic [7:0] rx_prog,
	input wire logic [7:0] tx_prog,
	// Levels
	output logic [7:0] rx_lvl,
	output logic [7:0] tx_lvl
);
	// One table field serves both directions
	always_comb begin
		unique case (tbl)
			2'b00: begin
				rx_lvl = RX_TBL_A[rx_fld];
				tx_lvl = TX_LVL_A;
			end
			2'b01: begin
				rx_lvl = RX_TBL_B[rx_fld];
				tx_lvl = TX_TBL_B[tx_fld];
			end
			2'b10: begin
				rx_lvl = RX_TBL_C[rx_fld];
				tx_lvl = TX_TBL_C[tx_fld];
			end
			2'b11: begin
				rx_lvl = rx_prog;
				tx_lvl = tx_prog;
			end
		endcase
	end
endmodule

`default_nettype wire

// [rtl/uaft_top.sv]
`timescale 1ns/1ps
`default_nettype none

module uaft_top
	import uaft_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Transmit stream towards the shift register
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// Receive stream from the shift register
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	// Pins and status
	output logic tx_ready_pin_n,
	output logic rx_ready_pin_n,
	output logic tx_irq,
	output logic rx_irq,
	output logic [3:0] char_len
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic fifo_en_r;
	logic dma_r;
	logic enh_r;
	logic tsel_r;
	logic [1:0] rx_fld_r;
	logic [1:0] tx_fld_r;
	logic [1:0] tbl_r;
	logic [7:0] lcr_r;
	logic [7:0] rx_prog_r;
	logic [7:0] tx_prog_r;
	logic rx_clr_r;
	logic tx_clr_r;
	logic [7:0] tx_prev_r;
	logic tx_over_r;
	logic [7:0] rx_hold_r;
	logic rx_hold_v_r;
	logic rx_hold_v_nxt;
	logic [7:0] rx_lvl;
	logic [7:0] tx_lvl;
	logic [7:0] rx_cnt8;
	logic [7:0] tx_cnt8;
	logic wr_data;
	logic wr_fcr;
	logic rd_data;
	logic rd_isr;
	logic dma_on;
	logic tx_fall;
	logic tx_empty_ev;
	logic tx_set;
	logic tx_ack;
	logic fcr_en_chg;

	uaft_fifo_if #(.W(DATA_W), .D(FIFO_DEPTH)) txq();
	uaft_fifo_if #(.W(DATA_W), .D(FIFO_DEPTH)) rxq();

	////////////////////////////////////////////////////////////////////////
	// Decode
	assign wr_data = reg_wr && reg_addr == OFS_DATA;
	assign wr_fcr = reg_wr && reg_addr == OFS_ISR_FCR;
	assign rd_data = reg_rd && reg_addr == OFS_DATA;
	assign rd_isr = reg_rd && reg_addr == OFS_ISR_FCR;
	assign fcr_en_chg = reg_wdata[FCR_EN] != fifo_en_r;
	assign dma_on = dma_r && fifo_en_r;
	assign rx_cnt8 = 8'(rxq.count);
	assign tx_cnt8 = 8'(txq.count);

	////////////////////////////////////////////////////////////////////////
	// Setup register, write-only
	always_ff @(posedge mclk) begin
		if (rst) begin
			fifo_en_r <= 1'b0;
			dma_r <= 1'b0;
			rx_fld_r <= 2'b00;
			tx_fld_r <= 2'b00;
		end else if (wr_fcr) begin
			fifo_en_r <= reg_wdata[FCR_EN];
			if (reg_wdata[FCR_EN]) begin
				dma_r <= reg_wdata[FCR_DMA];
				rx_fld_r <= reg_wdata[FCR_RXT +: 2];
				if (enh_r)
					tx_fld_r <= reg_wdata[FCR_TXT +: 2];
			end
		end
	end

	// Clear pulses last one cycle, so the bits read back as done by themselves.
	// Toggling the enable also flushes both queues; the receive hold word and the transmit output stage keep their words.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_clr_r <= 1'b0;
			tx_clr_r <= 1'b0;
		end else begin
			rx_clr_r <= wr_fcr && ((reg_wdata[FCR_EN] && reg_wdata[FCR_RXCLR]) || fcr_en_chg);
			tx_clr_r <= wr_fcr && ((reg_wdata[FCR_EN] && reg_wdata[FCR_TXCLR]) || fcr_en_chg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Format, enhanced and feature registers
	always_ff @(posedge mclk) begin
		if (rst)
			lcr_r <= LCR_RST;
		else if (reg_wr && reg_addr == OFS_LCR)
			lcr_r <= reg_wdata;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			enh_r <= 1'b0;
		else if (reg_wr && reg_addr == OFS_EFR)
			enh_r <= reg_wdata[EFR_ENH];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tbl_r <= 2'b00;
			tsel_r <= 1'b0;
		end else if (reg_wr && reg_addr == OFS_FEATURE_CONTROL_REG) begin
			tbl_r <= reg_wdata[FEATURE_CONTROL_REG_TBL +: 2];
			tsel_r <= reg_wdata[FEATURE_CONTROL_REG_TSEL];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_prog_r <= TRG_RST;
			tx_prog_r <= TRG_RST;
		end else if (reg_wr && reg_addr == OFS_TRG) begin
			if (tsel_r)
				tx_prog_r <= reg_wdata;
			else
				rx_prog_r <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst)
			char_len <= CHAR_LEN_MIN;
		else
			char_len <= CHAR_LEN_MIN + {2'b00, lcr_r[1:0]};
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger levels
	uaft_trig_sel u_trig (
		.tbl(tbl_r),
		.rx_fld(rx_fld_r),
		.tx_fld(tx_fld_r),
		.rx_prog(rx_prog_r),
		.tx_prog(tx_prog_r),
		.rx_lvl(rx_lvl),
		.tx_lvl(tx_lvl)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmit path; holding mode admits one word only
	assign txq.clear = tx_clr_r;
	assign txq.wdata = reg_wdata;
	assign txq.wvalid = wr_data && (fifo_en_r || txq.count == '0);
	assign txq.rready = !tx_valid || tx_ready;

	uaft_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_txq (
		.mclk(mclk),
		.rst(rst),
		.q(txq)
	);

	// Output stage stands for the shift register and is never flushed
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else if (txq.rready) begin
			tx_valid <= txq.rvalid;
			tx_data <= txq.rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive path; the hold word is the shift register side, untouched by a flush
	assign rxq.clear = rx_clr_r;
	assign rxq.wdata = rx_hold_r;
	assign rxq.wvalid = rx_hold_v_r && (fifo_en_r || rxq.count == '0);
	assign rxq.rready = rd_data;
	assign rx_hold_v_nxt = (rx_valid && rx_ready) ||
		(rx_hold_v_r && !(rxq.wvalid && rxq.wready));

	uaft_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rxq (
		.mclk(mclk),
		.rst(rst),
		.q(rxq)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_hold_v_r <= 1'b0;
			rx_ready <= 1'b1;
			rx_hold_r <= 8'h00;
		end else begin
			rx_hold_v_r <= rx_hold_v_nxt;
			rx_ready <= !rx_hold_v_nxt;
			if (rx_valid && rx_ready)
				rx_hold_r <= rx_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt sources
	always_ff @(posedge mclk) begin
		if (rst)
			rx_irq <= 1'b0;
		else if (fifo_en_r)
			rx_irq <= rx_cnt8 >= rx_lvl;
		else
			rx_irq <= rx_cnt8 != 8'h00;
	end

	assign tx_fall = tx_prev_r >= tx_lvl && tx_cnt8 < tx_lvl;
	assign tx_empty_ev = tx_prev_r != 8'h00 && tx_cnt8 == 8'h00;
	assign tx_set = fifo_en_r ? (tx_fall || (tx_empty_ev && !tx_over_r)) : tx_empty_ev;
	assign tx_ack = wr_data || (rd_isr && !rx_irq);

	// Remembers whether the last reload went above the trigger
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_prev_r <= 8'h00;
			tx_over_r <= 1'b0;
		end else begin
			tx_prev_r <= tx_cnt8;
			tx_over_r <= tx_cnt8 > tx_lvl || (tx_over_r && tx_cnt8 != 8'h00);
		end
	end

	// A new event in the acknowledge cycle wins
	always_ff @(posedge mclk) begin
		if (rst)
			tx_irq <= 1'b0;
		else
			tx_irq <= tx_set || (tx_irq && !tx_ack);
	end

	////////////////////////////////////////////////////////////////////////
	// Ready pins; DMA mode holds receive between trigger and empty, transmit between full and empty
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_ready_pin_n <= 1'b1;
			tx_ready_pin_n <= 1'b0;
		end else if (dma_on) begin
			if (rx_cnt8 >= rx_lvl)
				rx_ready_pin_n <= 1'b0;
			else if (rx_cnt8 == 8'h00)
				rx_ready_pin_n <= 1'b1;
			if (!txq.wready)
				tx_ready_pin_n <= 1'b1;
			else if (tx_cnt8 == 8'h00)
				tx_ready_pin_n <= 1'b0;
		end else begin
			rx_ready_pin_n <= rx_cnt8 == 8'h00;
			tx_ready_pin_n <= tx_cnt8 != 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port; setup register is write-only, its offset returns status
	always_ff @(posedge mclk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				OFS_DATA: reg_rdata <= rxq.rvalid ? rxq.rdata : 8'h00;
				OFS_ISR_FCR: begin
					reg_rdata <= 8'h00;
					reg_rdata[ISR_FEN +: 2] <= {2{fifo_en_r}};
					reg_rdata[3:0] <= rx_irq ? ISR_RX_READY_PIN_N : (tx_irq ? ISR_TX_READY_PIN_N : ISR_NONE);
				end
				OFS_LCR: reg_rdata <= lcr_r;
				OFS_EFR: reg_rdata <= 8'(enh_r) << EFR_ENH;
				OFS_FEATURE_CONTROL_REG: reg_rdata <= (8'(tsel_r) << FEATURE_CONTROL_REG_TSEL) | (8'(tbl_r) << FEATURE_CONTROL_REG_TBL);
				OFS_TRG: reg_rdata <= tsel_r ? tx_prog_r : rx_prog_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	isr_fifo_bits_a: assert property (rd_isr |=> reg_rdata[7:6] == {2{$past(fifo_en_r)}})
		else $error("fifo enable status bits wrong");
	fifo_disable_a: assert property (wr_fcr && !reg_wdata[FCR_EN] |=> !fifo_en_r)
		else $error("fifo enable not cleared");
	fcr_gate_a: assert property (wr_fcr && !reg_wdata[FCR_EN] |=> $stable(dma_r) && $stable(rx_fld_r))
		else $error("setup bits programmed without enable");
	rx_flush_a: assert property (wr_fcr && reg_wdata[FCR_EN] && reg_wdata[FCR_RXCLR]
		|=> rx_clr_r ##1 rxq.count == '0 && $stable(rx_hold_r))
		else $error("receive flush failed");
	tx_flush_a: assert property (wr_fcr && reg_wdata[FCR_EN] && reg_wdata[FCR_TXCLR]
		|=> tx_clr_r ##1 txq.count == '0)
		else $error("transmit flush failed");
	clr_pulse_a: assert property (rx_clr_r && !wr_fcr |=> !rx_clr_r)
		else $error("flush bit did not self clear");
	rx_pin_norm_a: assert property (!dma_on && rxq.count != '0 |=> !rx_ready_pin_n)
		else $error("receive ready pin wrong in normal mode");
	tx_irq_empty_a: assert property (fifo_en_r && tx_empty_ev && !tx_over_r |=> tx_irq)
		else $error("transmit empty interrupt missing");
	tx_fld_lock_a: assert property (!enh_r |=> $stable(tx_fld_r))
		else $error("transmit trigger changed while locked");
	rx_irq_set_a: assert property (fifo_en_r && rx_cnt8 >= rx_lvl |=> rx_irq)
		else $error("receive interrupt missing at trigger");
	rx_irq_drop_a: assert property (fifo_en_r && rx_cnt8 < rx_lvl |=> !rx_irq)
		else $error("receive interrupt held below trigger");
	trig_tbl_a: assert property (tbl_r == 2'b01 && rx_fld_r == 2'b11 |-> rx_lvl == RX_TBL_B[3])
		else $error("receive trigger table lookup wrong");
	prog_lvl_a: assert property (tbl_r == 2'b11 |-> tx_lvl == tx_prog_r && rx_lvl == rx_prog_r)
		else $error("programmable trigger not used");
	char_len_a: assert property (1'b1 |=> char_len == CHAR_LEN_MIN + {2'b00, $past(lcr_r[1:0])})
		else $error("character length wrong");
	hold_mode_a: assert property (!fifo_en_r && !tx_clr_r && txq.count <= 1 |=> txq.count <= 1)
		else $error("holding mode stored more than one word");

	rx_trig_c: cover property (fifo_en_r && rx_irq && rx_lvl > 8'h01);
	tx_ack_c: cover property (tx_irq ##1 wr_data ##1 !tx_irq);
	dma_pin_c: cover property (dma_on && !rx_ready_pin_n && rxq.count != '0);
	tx_full_c: cover property (!txq.wready);

endmodule

`default_nettype wire

// [tb/uaft_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Host on the register port: one-cycle strobes, released lines never keep the last value
module uaft_host_model
	import uaft_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Register port
	output logic [2:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 3'h7;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge mclk);
		v = reg_rdata;
	endtask

	// Enable bit always set, else the other fields would be lost
	task automatic set_fifo(input logic dma, input logic [1:0] rxf, input logic [1:0] txf,
		input logic rxc, input logic txc);
		wr(OFS_ISR_FCR, {rxf, txf, dma, txc, rxc, 1'b1});
	endtask
endmodule

`default_nettype wire

// [tb/tb_uart_fifo_trigger_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_uart_fifo_trigger_control
	import uaft_pkg::*;
;
	logic mclk, rst, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, rx_ready;
	logic tx_ready_pin_n, rx_ready_pin_n, tx_irq, rx_irq;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, d, e;
	logic [3:0] char_len;
	logic [7:0] rxq[$];
	logic [7:0] tq[$];
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int lv;

	uaft_top uaft_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_ready_pin_n(tx_ready_pin_n), .rx_ready_pin_n(rx_ready_pin_n),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .char_len(char_len));
	uaft_host_model uaft_host_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic int rx_lvl(int t, int f);
		int tab[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
		return tab[t][f];
	endfunction

	function automatic int tx_lvl(int t, int f);
		int tab[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
		return tab[t][f];
	endfunction

	task automatic tally_and_finish();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		uaft_host_model_i.wr(a, v);
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		uaft_host_model_i.rd(a, v);
	endtask

	task automatic setf(input logic dma, input logic [1:0] rf, input logic [1:0] tf,
		input logic rc, input logic tc);
		uaft_host_model_i.set_fifo(dma, rf, tf, rc, tc);
	endtask

	task automatic push_rx(input logic [7:0] v);
		@(posedge mclk);
		while (rx_ready !== 1'b1) @(posedge mclk);
		rx_data <= v;
		rx_valid <= 1'b1;
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_data <= ~v;
		rxq.push_back(v);
	endtask

	task automatic take_tx(output logic [7:0] v);
		@(posedge mclk);
		while (tx_valid !== 1'b1) @(posedge mclk);
		tx_ready <= 1'b1;
		v = tx_data;
		@(posedge mclk);
		tx_ready <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic rx_case(input logic [1:0] t, input logic [1:0] f, input int lvl);
		logic [7:0] v, x;
		wr(OFS_FEATURE_CONTROL_REG, {2'b00, t, 4'h0});
		setf(1'b0, f, 2'b00, 1'b1, 1'b0);
		rxq.delete();
		repeat (lvl - 1) push_rx(8'($urandom));
		repeat (4) @(posedge mclk);
		`CHK(rx_irq, 1'b0)
		push_rx(8'($urandom));
		repeat (4) @(posedge mclk);
		`CHK(rx_irq, 1'b1)
		rd(OFS_DATA, v);
		x = rxq.pop_front();
		`CHK(v, x)
		repeat (3) @(posedge mclk);
		`CHK(rx_irq, 1'b0)
		setf(1'b0, f, 2'b00, 1'b1, 1'b0);
		repeat (3) @(posedge mclk);
		`CHK(rx_ready_pin_n, 1'b1)
		rd(OFS_DATA, v);
		`CHK(v, 8'h00)
	endtask

	// Fill past the trigger, then count takes until the interrupt appears
	task automatic tx_case(input logic [1:0] t, input logic [1:0] f, input int lvl);
		logic [7:0] v;
		int n;
		wr(OFS_FEATURE_CONTROL_REG, {2'b00, t, 4'h0});
		setf(1'b0, 2'b00, f, 1'b0, 1'b1);
		repeat (lvl + 3) wr(OFS_DATA, 8'($urandom));
		n = 0;
		while (tx_irq !== 1'b1 && n < 8) begin
			take_tx(v);
			n++;
			repeat (4) @(posedge mclk);
		end
		`CHK(n, 3)
		setf(1'b0, 2'b00, f, 1'b0, 1'b1);
		repeat (3) @(posedge mclk);
		`CHK(tx_ready_pin_n, 1'b0)
		`CHK(tx_valid, 1'b1)
		take_tx(v);
		repeat (2) @(posedge mclk);
		`CHK(tx_valid, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		d = 8'($urandom(32'h0000_0639));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(OFS_ISR_FCR, d);
		`CHK(d, 8'h01)
		`CHK(char_len, 4'h5)
		`CHK(tx_ready_pin_n, 1'b0)
		`CHK(rx_ready_pin_n, 1'b1)
		rd(3'h1, d);
		`CHK(d, 8'h00)
		rd(3'h7, d);
		`CHK(d, 8'h00)
		for (int v = 0; v < 4; v++) begin
			e = {6'($urandom), 2'(v)};
			wr(OFS_LCR, e);
			rd(OFS_LCR, d);
			`CHK(d, e)
			`CHK(char_len, 4'(5 + v))
		end
		// Disabled: one word each in queue and hold, triggers ignored
		rxq.delete();
		push_rx(8'($urandom));
		push_rx(8'($urandom));
		repeat (4) @(posedge mclk);
		`CHK(rx_irq, 1'b1)
		`CHK(rx_ready, 1'b0)
		repeat (2) begin
			rd(OFS_DATA, d);
			e = rxq.pop_front();
			`CHK(d, e)
			repeat (4) @(posedge mclk);
		end
		`CHK(rx_irq, 1'b0)
		wr(OFS_ISR_FCR, 8'h01);
		rd(OFS_ISR_FCR, d);
		`CHK(d[7:6], 2'b11)
		wr(OFS_ISR_FCR, 8'h0e);
		rd(OFS_ISR_FCR, d);
		`CHK(d[7:6], 2'b00)
		for (int t = 0; t < 3; t++) begin
			for (int f = 0; f < 4; f++) begin
				if (rx_lvl(t, f) <= 28) begin
					rx_case(2'(t), 2'(f), rx_lvl(t, f));
				end
			end
		end
		lv = 2 + $urandom % 20;
		wr(OFS_TRG, 8'(lv));
		rx_case(2'd3, 2'($urandom), lv);
		tx_case(2'd1, 2'd2, 16);
		wr(OFS_EFR, 8'h10);
		for (int t = 1; t < 3; t++) begin
			for (int f = 0; f < 4; f++) begin
				if (tx_lvl(t, f) <= 30) begin
					tx_case(2'(t), 2'(f), tx_lvl(t, f));
				end
			end
		end
		tx_case(2'd0, 2'($urandom), 1);
		// Pins: normal then DMA; fill until a write is refused, drain with stalls
		wr(OFS_FEATURE_CONTROL_REG, 8'h00);
		setf(1'b0, 2'b00, 2'b00, 1'b1, 1'b1);
		tq.delete();
		for (int i = 0; i < 5; i++) begin
			e = 8'($urandom);
			wr(OFS_DATA, e);
			if (i == 0) begin
				tq.push_back(e);
			end
		end
		repeat (3) @(posedge mclk);
		`CHK(tx_ready_pin_n, 1'b1)
		setf(1'b1, 2'b00, 2'b00, 1'b0, 1'b1);
		for (int i = 0; i < 33; i++) begin
			e = 8'($urandom);
			wr(OFS_DATA, e);
			if (i < 32) begin
				tq.push_back(e);
			end
			if (i == 5) begin
				`CHK(tx_ready_pin_n, 1'b0)
			end
		end
		repeat (3) @(posedge mclk);
		`CHK(tx_ready_pin_n, 1'b1)
		while (tq.size() > 0) begin
			repeat ($urandom % 3) @(posedge mclk);
			take_tx(d);
			e = tq.pop_front();
			`CHK(d, e)
		end
		repeat (3) @(posedge mclk);
		`CHK(tx_valid, 1'b0)
		`CHK(tx_ready_pin_n, 1'b0)
		tally_and_finish();
	end
endmodule

`default_nettype wire
